// ---- design/sbrc_standby_ram_ctrl.sv ----
// Standby control and on-chip RAM enable control registers
// How it works
// - A sleep instruction enters sleep when standby select is 0 and software standby when it is 1, reset value 0.
// - A write of 1 to standby select is refused while the watchdog timer enable is 1.
// - In software standby ports hold when port float select is 0 and float when it is 1, reset value 0.
// - A write of 1 to port float select is refused while the watchdog timer enable is 1.
// - Standby control bit 5 reads 0 and bits 4 to 1 read 1, none of them writable.
// - The IRQ wake control bit resets to 1 and lets the IRQ lines clear standby only when 0.
// - With the RAM enable bit at 0 RAM reads return a fixed filler and RAM writes are dropped.
// - With the RAM enable bit at 1 RAM is reached normally, and it resets to 1.
// - System control bits 7 and 6 read 1 and bits 5 to 1 read 0, none of them writable.
//
// Our own choices: the register offsets and strobed register access.
`default_nettype none
module sbrc_standby_ram_ctrl (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Watchdog interlock
  input  wire logic        watchdog_timer_enable,
  // Sleep and wake
  input  wire logic        sleep_exec,
  input  wire logic        in_standby,
  input  wire logic [3:0]  irq_req,
  output logic             mode_req,
  output var sbrc_pkg::sbrc_mode_type mode_sel,
  output logic             mode_port_float,
  output logic             irq_wake,
  output logic             port_float_active,
  // CPU side of the on-chip RAM
  input  wire logic        cpu_ram_rd,
  input  wire logic        cpu_ram_wr,
  output logic      [31:0] cpu_ram_rdata,
  // Array side of the on-chip RAM
  input  wire logic [31:0] ram_rdata,
  output logic             ram_rd,
  output logic             ram_wr
);

  logic       stby_sel_r, stby_sel_nxt;
  logic       port_float_r, port_float_nxt;
  logic       irq_wake_ctl_r, irq_wake_ctl_nxt;
  logic       ram_en_r, ram_en_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       mode_req_r, mode_req_nxt;
  sbrc_pkg::sbrc_mode_type mode_r, mode_nxt;
  logic       mode_float_r, mode_float_nxt;

  // Read image of each register with fixed reserved bits
  function automatic logic [7:0] read_image(input logic [3:0] a, input logic ss, input logic pf,
                                            input logic iw, input logic re);
    logic [7:0] v;
    v = 8'h00;
    if (a == sbrc_pkg::ADDR_STANDBY_CONTROL) begin
      v = sbrc_pkg::STBY_FIXED_VAL;
      v[sbrc_pkg::STBY_SEL_POS]   = ss;
      v[sbrc_pkg::PORT_FLOAT_POS] = pf;
      v[sbrc_pkg::IRQ_WAKE_POS]   = iw;
    end else if (a == sbrc_pkg::ADDR_SYSTEM_CONTROL) begin
      v = sbrc_pkg::SYS_FIXED_VAL;
      v[sbrc_pkg::RAM_EN_POS] = re;
    end
    return v;
  endfunction

  // Register writes; the watchdog interlock only blocks setting, never clearing
  always_comb begin
    stby_sel_nxt     = stby_sel_r;
    port_float_nxt   = port_float_r;
    irq_wake_ctl_nxt = irq_wake_ctl_r;
    ram_en_nxt       = ram_en_r;
    if (reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL) begin
      if (!(reg_wdata[sbrc_pkg::STBY_SEL_POS] && watchdog_timer_enable)) begin
        stby_sel_nxt = reg_wdata[sbrc_pkg::STBY_SEL_POS];
      end
      if (!(reg_wdata[sbrc_pkg::PORT_FLOAT_POS] && watchdog_timer_enable)) begin
        port_float_nxt = reg_wdata[sbrc_pkg::PORT_FLOAT_POS];
      end
      irq_wake_ctl_nxt = reg_wdata[sbrc_pkg::IRQ_WAKE_POS];
    end
    if (reg_wr && reg_addr == sbrc_pkg::ADDR_SYSTEM_CONTROL) begin
      ram_en_nxt = reg_wdata[sbrc_pkg::RAM_EN_POS];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      rdata_nxt = read_image(reg_addr, stby_sel_r, port_float_r, irq_wake_ctl_r, ram_en_r);
    end
  end

  // Sleep request: mode chosen from standby select at the instruction
  always_comb begin
    mode_req_nxt   = sleep_exec;
    mode_nxt       = sbrc_pkg::SBRC_RUN;
    mode_float_nxt = mode_float_r;
    if (sleep_exec) begin
      mode_nxt       = stby_sel_r ? sbrc_pkg::SBRC_STANDBY : sbrc_pkg::SBRC_SLEEP;
      mode_float_nxt = port_float_r;
    end else begin
      mode_nxt = mode_r;
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stby_sel_r     <= sbrc_pkg::STBY_SEL_RST;
      port_float_r   <= sbrc_pkg::PORT_FLOAT_RST;
      irq_wake_ctl_r <= sbrc_pkg::IRQ_WAKE_RST;
      ram_en_r       <= sbrc_pkg::RAM_EN_RST;
      rdata_r        <= 8'h00;
      mode_req_r     <= 1'b0;
      mode_r         <= sbrc_pkg::SBRC_RUN;
      mode_float_r   <= 1'b0;
    end else if (clk_en) begin
      stby_sel_r     <= stby_sel_nxt;
      port_float_r   <= port_float_nxt;
      irq_wake_ctl_r <= irq_wake_ctl_nxt;
      ram_en_r       <= ram_en_nxt;
      rdata_r        <= rdata_nxt;
      mode_req_r     <= mode_req_nxt;
      mode_r         <= mode_nxt;
      mode_float_r   <= mode_float_nxt;
    end
  end

  // Outputs
  assign reg_rdata       = rdata_r;
  assign mode_req        = mode_req_r;
  assign mode_sel        = mode_r;
  assign mode_port_float = mode_float_r;
  // Any IRQ line may wake standby only when wake control is 0
  assign irq_wake        = in_standby && !irq_wake_ctl_r && (|irq_req);
  // Ports float only while in software standby with float chosen
  assign port_float_active = in_standby && port_float_r;

  // RAM gate: combinational so RAM keeps its one-cycle access
  assign ram_rd        = cpu_ram_rd && ram_en_r;
  assign ram_wr        = cpu_ram_wr && ram_en_r;
  assign cpu_ram_rdata = ram_en_r ? ram_rdata : sbrc_pkg::RAM_BLOCKED_DATA;

  // Checks
  property p_stby_refused;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL && watchdog_timer_enable && !stby_sel_r)
      |=> !stby_sel_r;
  endproperty
  a_stby_refused: assert property (p_stby_refused) else $error("standby select set while watchdog on");

  property p_float_refused;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL && watchdog_timer_enable && !port_float_r)
      |=> !port_float_r;
  endproperty
  a_float_refused: assert property (p_float_refused) else $error("port float set while watchdog on");

  property p_mode_sel;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && sleep_exec) |=> mode_req && (mode_sel == ($past(stby_sel_r) ? sbrc_pkg::SBRC_STANDBY
                                                             : sbrc_pkg::SBRC_SLEEP));
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("wrong low-power mode chosen");

  property p_float_out;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && sleep_exec) |=> mode_port_float == $past(port_float_r);
  endproperty
  a_float_out: assert property (p_float_out) else $error("port float choice not passed");

  property p_stby_read;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_rd && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL)
      |=> (reg_rdata & sbrc_pkg::STBY_FIXED_MASK) == sbrc_pkg::STBY_FIXED_VAL;
  endproperty
  a_stby_read: assert property (p_stby_read) else $error("standby reserved bits wrong");

  property p_sys_read;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_rd && reg_addr == sbrc_pkg::ADDR_SYSTEM_CONTROL)
      |=> reg_rdata[7:1] == sbrc_pkg::SYS_FIXED_VAL[7:1];
  endproperty
  a_sys_read: assert property (p_sys_read) else $error("system control reserved bits wrong");

  property p_ram_block;
    @(posedge sys_clk) disable iff (srst)
      !ram_en_r |-> !ram_wr && !ram_rd;
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("RAM reached while disabled");

  property p_ram_open;
    @(posedge sys_clk) disable iff (srst)
      (ram_en_r && cpu_ram_wr) |-> ram_wr;
  endproperty
  a_ram_open: assert property (p_ram_open) else $error("RAM write lost while enabled");

  property p_irq_wake;
    @(posedge sys_clk) disable iff (srst)
      (in_standby && |irq_req) |-> (irq_wake == !irq_wake_ctl_r);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("IRQ wake gating wrong");

  property p_port_float;
    @(posedge sys_clk) disable iff (srst)
      in_standby |-> (port_float_active == port_float_r);
  endproperty
  a_port_float: assert property (p_port_float) else $error("port float state wrong in standby");

  // Checks on freezing, idle outputs, RAM read data and write acceptance
  property p_freeze;
    @(posedge sys_clk) disable iff (srst)
      !clk_en |=> $stable(stby_sel_r) && $stable(port_float_r) && $stable(irq_wake_ctl_r) && $stable(ram_en_r)
                  && $stable(reg_rdata) && $stable(mode_req) && $stable(mode_sel) && $stable(mode_port_float);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_rdata_idle;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stands without a read");

  property p_irq_quiet;
    @(posedge sys_clk) disable iff (srst)
      !in_standby |-> !irq_wake;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("IRQ wake outside standby");

  property p_float_quiet;
    @(posedge sys_clk) disable iff (srst)
      !in_standby |-> !port_float_active;
  endproperty
  a_float_quiet: assert property (p_float_quiet) else $error("ports float outside standby");

  property p_ram_pass;
    @(posedge sys_clk) disable iff (srst)
      (ram_en_r && cpu_ram_rd) |-> ram_rd && (cpu_ram_rdata == ram_rdata);
  endproperty
  a_ram_pass: assert property (p_ram_pass) else $error("RAM read blocked while enabled");

  property p_ram_fill;
    @(posedge sys_clk) disable iff (srst)
      !ram_en_r |-> cpu_ram_rdata == sbrc_pkg::RAM_BLOCKED_DATA;
  endproperty
  a_ram_fill: assert property (p_ram_fill) else $error("RAM data leaks while disabled");

  property p_stby_clear;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL && !reg_wdata[sbrc_pkg::STBY_SEL_POS])
      |=> !stby_sel_r;
  endproperty
  a_stby_clear: assert property (p_stby_clear) else $error("standby select clear refused");

  property p_float_clear;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL && !reg_wdata[sbrc_pkg::PORT_FLOAT_POS])
      |=> !port_float_r;
  endproperty
  a_float_clear: assert property (p_float_clear) else $error("port float clear refused");

  property p_stby_take;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL && !watchdog_timer_enable
       && reg_wdata[sbrc_pkg::STBY_SEL_POS]) |=> stby_sel_r;
  endproperty
  a_stby_take: assert property (p_stby_take) else $error("standby select set lost with watchdog off");

  property p_ram_en_wr;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_SYSTEM_CONTROL)
      |=> ram_en_r == $past(reg_wdata[sbrc_pkg::RAM_EN_POS]);
  endproperty
  a_ram_en_wr: assert property (p_ram_en_wr) else $error("RAM enable write lost");

  property p_mode_once;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && !sleep_exec) |=> !mode_req;
  endproperty
  a_mode_once: assert property (p_mode_once) else $error("mode request longer than one cycle");

  property p_wake_ctl_wr;
    @(posedge sys_clk) disable iff (srst)
      (clk_en && reg_wr && reg_addr == sbrc_pkg::ADDR_STANDBY_CONTROL)
      |=> irq_wake_ctl_r == $past(reg_wdata[sbrc_pkg::IRQ_WAKE_POS]);
  endproperty
  a_wake_ctl_wr: assert property (p_wake_ctl_wr) else $error("IRQ wake control write lost");

endmodule
`default_nettype wire

// ---- design/sbrc_pkg.sv ----
// Package for the standby and RAM enable control block
`default_nettype none
package sbrc_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_STANDBY_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SYSTEM_CONTROL  = 4'h1;
  // Standby control field positions
  localparam int STBY_SEL_POS   = 7;
  localparam int PORT_FLOAT_POS = 6;
  localparam int IRQ_WAKE_POS   = 0;
  // System control field positions
  localparam int RAM_EN_POS     = 0;
  // Reset values of the writable bits
  localparam logic STBY_SEL_RST   = 1'b0;
  localparam logic PORT_FLOAT_RST = 1'b0;
  localparam logic IRQ_WAKE_RST   = 1'b1;
  localparam logic RAM_EN_RST     = 1'b1;
  // Fixed read patterns of reserved bits
  localparam logic [7:0] STBY_FIXED_MASK = 8'h3e;
  localparam logic [7:0] STBY_FIXED_VAL  = 8'h1e;
  localparam logic [7:0] SYS_FIXED_VAL   = 8'hc0;
  // Undefined value returned by a blocked RAM read
  localparam logic [31:0] RAM_BLOCKED_DATA = 32'h0000_0000;
  // Run mode and the low-power target modes
  typedef enum logic [1:0] {SBRC_RUN, SBRC_SLEEP, SBRC_STANDBY} sbrc_mode_type;
endpackage
`default_nettype wire

// ---- bench/sbrc_standby_ram_ctrl_tb.sv ----
// Self-checking testbench for the standby and RAM enable control block
`default_nettype none
module sbrc_standby_ram_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    sys_clk, srst, clk_en, reg_wr, reg_rd, wd_run, sleep_exec, in_standby;
  logic                    cpu_ram_rd, cpu_ram_wr, mode_req, mode_port_float, irq_wake, port_float_active;
  logic                    ram_rd, ram_wr;
  logic [3:0]              reg_addr, irq_req;
  logic [7:0]              reg_wdata, reg_rdata;
  logic [31:0]             ram_rdata, cpu_ram_rdata;
  sbrc_pkg::sbrc_mode_type mode_sel;
  int                      error_cnt = 0;
  int                      checks = 0;

  sbrc_standby_ram_ctrl sbrc_standby_ram_ctrl_i (.sys_clk, .srst, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .watchdog_timer_enable(wd_run), .sleep_exec, .in_standby, .irq_req, .mode_req,
    .mode_sel, .mode_port_float, .irq_wake, .port_float_active, .cpu_ram_rd, .cpu_ram_wr, .cpu_ram_rdata,
    .ram_rdata, .ram_rd, .ram_wr);

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(32'(reg_rdata), 32'(e));
  endtask

  // Sleep pulse, then the mode request must last exactly one cycle
  task automatic sleep_chk(input sbrc_pkg::sbrc_mode_type m, input logic f);
    @(posedge sys_clk);
    sleep_exec <= 1'b1;
    @(posedge sys_clk);
    sleep_exec <= 1'b0;
    #1 chk(32'(mode_req), 32'h0000_0001);
    chk(32'(mode_sel), 32'(m));
    chk(32'(mode_port_float), 32'(f));
    @(posedge sys_clk);
    #1 chk(32'(mode_req), 32'h0000_0000);
  endtask

  // RAM strobes for one cycle; a blocked RAM gives no strobes and a zero filler
  task automatic ram_chk(input logic en);
    @(posedge sys_clk);
    cpu_ram_rd <= 1'b1;
    cpu_ram_wr <= 1'b1;
    ram_rdata  <= 32'h5a5a_c3c3;
    #1 chk(32'(ram_rd), 32'(en));
    chk(32'(ram_wr), 32'(en));
    chk(cpu_ram_rdata, en ? 32'h5a5a_c3c3 : 32'h0000_0000);
    @(posedge sys_clk);
    cpu_ram_rd <= 1'b0;
    cpu_ram_wr <= 1'b0;
  endtask

  task automatic t_interlock();
    @(posedge sys_clk);
    wd_run <= 1'b1;
    wr(4'h0, 8'hfe);
    rd(4'h0, 8'h1e);
    @(posedge sys_clk);
    wd_run <= 1'b0;
    wr(4'h0, 8'hc0);
    rd(4'h0, 8'hde);
    @(posedge sys_clk);
    wd_run <= 1'b1;
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h1f);
  endtask

  task automatic t_sleep();
    sleep_chk(sbrc_pkg::SBRC_SLEEP, 1'b0);
    @(posedge sys_clk);
    wd_run <= 1'b0;
    wr(4'h0, 8'hc0);
    sleep_chk(sbrc_pkg::SBRC_STANDBY, 1'b1);
    @(posedge sys_clk);
    in_standby <= 1'b1;
    irq_req    <= 4'h4;
    #1 chk(32'(port_float_active), 32'h0000_0001);
    chk(32'(irq_wake), 32'h0000_0001);
    wr(4'h0, 8'h81);
    #1 chk(32'(port_float_active), 32'h0000_0000);
    chk(32'(irq_wake), 32'h0000_0000);
    @(posedge sys_clk);
    in_standby <= 1'b0;
    irq_req    <= 4'h0;
  endtask

  // Clock enable low: a write and a sleep pulse are both ignored
  task automatic t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(4'h1, 8'hc0);
    @(posedge sys_clk);
    sleep_exec <= 1'b1;
    @(posedge sys_clk);
    sleep_exec <= 1'b0;
    #1 chk(32'(mode_req), 32'h0000_0000);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(4'h1, 8'hc1);
    ram_chk(1'b1);
  endtask

  // Reset in mid-run brings registers and the mode output back to their reset values
  task automatic t_reset();
    wr(4'h0, 8'hc0);
    wr(4'h1, 8'hc0);
    @(posedge sys_clk);
    srst <= 1'b1;
    @(posedge sys_clk);
    srst <= 1'b0;
    #1 chk(32'(mode_sel), 32'(sbrc_pkg::SBRC_RUN));
    rd(4'h0, 8'h1f);
    rd(4'h1, 8'hc1);
  endtask

  task automatic t_ram();
    ram_chk(1'b1);
    wr(4'h1, 8'hc0);
    rd(4'h1, 8'hc0);
    ram_chk(1'b0);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'hc1);
    ram_chk(1'b1);
  endtask

  // Hang guard
  initial begin
    #200us;
    error_cnt++;
    end_of_test();
  end

  // Reset, then the scenarios in turn
  initial begin
    {srst, clk_en, reg_wr, reg_rd, wd_run, sleep_exec, in_standby, cpu_ram_rd, cpu_ram_wr} = 9'h180;
    {reg_addr, irq_req, reg_wdata, ram_rdata} = 48'h0000_0000_0000;
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    rd(4'h0, 8'h1f);
    rd(4'h1, 8'hc1);
    rd(4'h5, 8'h00);
    t_interlock();
    t_sleep();
    t_ram();
    t_freeze();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
